// >>> pin_port_consts.vh
// Register offsets, reset values and timing figures for the pin port.
`ifndef PIN_PORT_CONSTS_VH
`define PIN_PORT_CONSTS_VH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define ADDR_PIN_DIRECTION 12'h000
`define ADDR_PIN_OUTPUT_STATE 12'h004
`define ADDR_SYSTEM_TICK_COUNT 12'h008
`define ADDR_WAIT_TARGET 12'h00c
`define ADDR_WAIT_STATUS 12'h010
`define ADDR_PIN_INPUT_STATE 12'h014
`define ADDR_CLOCK_RATE 12'h018

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define WAIT_STATUS_BUSY_BIT 0
`define RST_PIN_DIRECTION 32'h00000000
`define RST_PIN_OUTPUT_STATE 32'h00000000
`define RST_TICK_COUNT 32'h00000000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SYS_CLK_PERIOD_NS 8
`define DEFAULT_FAST_OSC_KHZ 12000

`endif

// >>> pin_sync.v
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps

module pin_sync #(
	parameter WIDTH = 32
) (
	input wire clk_sys_i,
	input wire reset_i,
	input wire [WIDTH-1:0] async_i,
	output reg [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] stage_one;

	// The first stage is read only by the second stage.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			stage_one <= {WIDTH{1'b0}};
			sync_o <= {WIDTH{1'b0}};
		end else begin
			stage_one <= async_i;
			sync_o <= stage_one;
		end
	end

endmodule // pin_sync

// >>> tick_counter.v
// Free-running system tick counter with an exact-match wait comparator.
`timescale 1ns/1ps

module tick_counter #(
	parameter WIDTH = 32
) (
	input wire clk_sys_i,
	input wire reset_i,
	input wire [WIDTH-1:0] target_i,
	output reg [WIDTH-1:0] count_o,
	output wire match_o
);

	// Count advances by one every cycle and wraps from all ones to zero.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			count_o <= {WIDTH{1'b0}};
		end else begin
			count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// Only exact equality ends a wait, so a passed target needs a wrap.
	assign match_o = (count_o == target_i);

endmodule // tick_counter

// >>> pin_port.v
// Top of the 32-pin port with tick counter and counter wait over APB.
//
// Notes on behaviour
// - Direction register, one bit per pin 0..31; 1 output, 0 input.
// - Output-state register drives each output pin low for 0, high for 1.
// - Output-state register reads back, so read-modify-write toggles one pin.
// - Tick-count register read returns the counter value at the read.
// - Counter wait stalls the processor until counter equals the target.
// - Counter advances by one every system clock cycle.
// - Without clock setup the system clock is the ~12 MHz fast oscillator.
`timescale 1ns/1ps
`include "pin_port_consts.vh"

module pin_port #(
	parameter PINS = 32,
	parameter CLK_KHZ = `DEFAULT_FAST_OSC_KHZ
) (
	input wire clk_sys_i,
	input wire reset_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	input wire [PINS-1:0] pin_in_i,
	output reg [PINS-1:0] pin_out_o,
	output reg [PINS-1:0] pin_oe_o,
	output reg cpu_stall_o
);

	// ----------------------------------------------------------------
	// Internal state
	// ----------------------------------------------------------------
	reg [PINS-1:0] pin_direction;
	reg [PINS-1:0] pin_output_state;
	reg [31:0] wait_target;
	reg waiting;
	wire [PINS-1:0] pin_sampled;
	wire [31:0] tick_count;
	wire tick_match;
	wire setup_phase;
	wire access_phase;
	wire wr_access;
	wire rd_setup;
	wire sel_direction;
	wire sel_output_state;
	wire sel_tick_count;
	wire sel_wait_target;
	wire sel_wait_status;
	wire sel_pin_input;
	wire sel_clock_rate;
	wire wr_direction;
	wire wr_output_state;
	wire wr_wait_target;
	wire arm_wait;
	wire wait_done;
	wire [PINS-1:0] next_pin_out;
	wire [PINS-1:0] next_pin_oe;
	reg addr_ok;
	reg [31:0] next_rdata;
	reg [31:0] next_prdata;
	reg next_pready;
	reg next_pslverr;
	reg next_waiting;
	reg next_stall;

	// Clock rate in kHz, readable so software can scale its waits.
	localparam [31:0] CLOCK_RATE_WORD = CLK_KHZ;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------

	// Pin levels come from outside and are synchronised first.
	pin_sync #(
		.WIDTH(PINS)
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.async_i(pin_in_i),
		.sync_o(pin_sampled)
	);

	// The system clock is taken as the fast oscillator by default.
	tick_counter #(
		.WIDTH(32)
	) u_tick_counter (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.target_i(wait_target),
		.count_o(tick_count),
		.match_o(tick_match)
	);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------

	// Every access completes in its first access cycle.
	assign setup_phase = psel_i & ~penable_i;
	assign access_phase = psel_i & penable_i & pready_o;
	assign wr_access = access_phase & pwrite_i & addr_ok;
	assign rd_setup = setup_phase & ~pwrite_i;

	// ----------------------------------------------------------------
	// Register select
	// ----------------------------------------------------------------

	// One select per mapped word; each register owns one aligned word.
	assign sel_direction = (paddr_i == `ADDR_PIN_DIRECTION);
	assign sel_output_state = (paddr_i == `ADDR_PIN_OUTPUT_STATE);
	assign sel_tick_count = (paddr_i == `ADDR_SYSTEM_TICK_COUNT);
	assign sel_wait_target = (paddr_i == `ADDR_WAIT_TARGET);
	assign sel_wait_status = (paddr_i == `ADDR_WAIT_STATUS);
	assign sel_pin_input = (paddr_i == `ADDR_PIN_INPUT_STATE);
	assign sel_clock_rate = (paddr_i == `ADDR_CLOCK_RATE);

	// Write strobes for the registers that software may change.
	assign wr_direction = wr_access & sel_direction;
	assign wr_output_state = wr_access & sel_output_state;
	assign wr_wait_target = wr_access & sel_wait_target;

	// A transfer is valid only on one of the mapped words.
	always @* begin
		addr_ok = sel_direction | sel_output_state | sel_tick_count |
			sel_wait_target | sel_wait_status | sel_pin_input |
			sel_clock_rate;
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------

	// Read data selection; every other word reads as zero.
	always @* begin
		next_rdata = 32'h00000000;
		if (sel_direction) begin
			next_rdata[PINS-1:0] = pin_direction;
		end
		if (sel_output_state) begin
			next_rdata[PINS-1:0] = pin_output_state;
		end
		if (sel_tick_count) begin
			next_rdata = tick_count;
		end
		if (sel_wait_target) begin
			next_rdata = wait_target;
		end
		if (sel_wait_status) begin
			next_rdata[`WAIT_STATUS_BUSY_BIT] = waiting;
		end
		if (sel_pin_input) begin
			next_rdata[PINS-1:0] = pin_sampled;
		end
		if (sel_clock_rate) begin
			next_rdata = CLOCK_RATE_WORD;
		end
	end

	// ----------------------------------------------------------------
	// Bus responses
	// ----------------------------------------------------------------

	// Ready, error and read data for the coming access cycle.
	always @* begin
		next_pready = setup_phase;
		next_pslverr = setup_phase & ~addr_ok;
		next_prdata = 32'h00000000;
		if (rd_setup) begin
			next_prdata = next_rdata;
		end
	end

	// Ready is raised in the setup cycle so the access phase lasts one.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			pready_o <= 1'b0;
		end else begin
			pready_o <= next_pready;
		end
	end

	// An unmapped word is flagged with ready; its write is dropped.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			pslverr_o <= 1'b0;
		end else begin
			pslverr_o <= next_pslverr;
		end
	end

	// Read data stand only in the access cycle and are zero otherwise.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			prdata_o <= 32'h00000000;
		end else begin
			prdata_o <= next_prdata;
		end
	end

	// ----------------------------------------------------------------
	// Pin registers
	// ----------------------------------------------------------------

	// Direction register: software chooses which pins drive.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			pin_direction <= `RST_PIN_DIRECTION;
		end else if (wr_direction) begin
			pin_direction <= pwdata_i[PINS-1:0];
		end
	end

	// Output-state register: the level each driving pin shows.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			pin_output_state <= `RST_PIN_OUTPUT_STATE;
		end else if (wr_output_state) begin
			pin_output_state <= pwdata_i[PINS-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------

	// Pins drive the stored level only where the direction is output.
	assign next_pin_out = pin_output_state & pin_direction;
	assign next_pin_oe = pin_direction;

	// Pin levels are registered so every pin output comes from a flop.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			pin_out_o <= {PINS{1'b0}};
		end else begin
			pin_out_o <= next_pin_out;
		end
	end

	// Output enables follow the direction register one cycle later.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			pin_oe_o <= {PINS{1'b0}};
		end else begin
			pin_oe_o <= next_pin_oe;
		end
	end

	// ----------------------------------------------------------------
	// Counter wait
	// ----------------------------------------------------------------

	// A target write arms the wait; an exact count match ends it.
	assign arm_wait = wr_wait_target;
	assign wait_done = waiting & tick_match;

	// Next wait state; a fresh target wins over a match in one cycle.
	always @* begin
		next_waiting = waiting;
		next_stall = cpu_stall_o;
		if (arm_wait) begin
			next_waiting = 1'b1;
			next_stall = 1'b1;
		end else if (wait_done) begin
			next_waiting = 1'b0;
			next_stall = 1'b0;
		end
	end

	// The target is held for the comparator until the next write.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			wait_target <= 32'h00000000;
		end else if (wr_wait_target) begin
			wait_target <= pwdata_i;
		end
	end

	// ----------------------------------------------------------------
	// Wait outputs
	// ----------------------------------------------------------------

	// Pending flag, read back through the status word.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			waiting <= 1'b0;
		end else begin
			waiting <= next_waiting;
		end
	end

	// Stall to the processor, high for as long as the wait is pending.
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			cpu_stall_o <= 1'b0;
		end else begin
			cpu_stall_o <= next_stall;
		end
	end

endmodule // pin_port

// >>> pin_loads.sv
// External loads on the port pins, with a weak pull-down on each line.
`timescale 1ns/1ps
module pin_loads(
	input wire [31:0] oe_i,
	input wire [31:0] out_i,
	output wire [31:0] level_o
);
	// A driven pin shows its level; a released one sinks to the pull-down.
	assign level_o = oe_i & out_i;
endmodule // pin_loads

// >>> pin_port_assertions.sv
// Checker for the pin port bus timing, pin outputs and wait flag.
`timescale 1ns/1ps
module pin_port_chk(
	input wire clk_sys_i,
	input wire reset_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	input wire [31:0] pin_out_o,
	input wire [31:0] pin_oe_o,
	input wire cpu_stall_o
);
	// Writes take effect at the access edge.
	wire wr = psel_i & penable_i & pready_o & pwrite_i;
	wire wr_dir = wr & (paddr_i == 12'h000);
	wire wr_tgt = wr & (paddr_i == 12'h00c);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	a_ready_after_setup: assert property (psel_i & !penable_i |=> pready_o)
		else $error("No ready after setup.");
	a_ready_one_cycle: assert property (pready_o |=> !pready_o)
		else $error("Ready held too long.");
	a_err_unmapped: assert property (pready_o |-> pslverr_o ==
		!(paddr_i[1:0] == 2'b00 && paddr_i <= 12'h018))
		else $error("Wrong error flag.");
	a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("Read data not zero when idle.");
	a_out_driven_only: assert property ((pin_out_o & ~pin_oe_o) == 32'h0)
		else $error("Level on an input pin.");
	a_dir_cause: assert property ($changed(pin_oe_o) |->
		$past(wr_dir) || $past(wr_dir, 2)) else $error("Stray direction.");
	a_stall_on_arm: assert property (wr_tgt |=> cpu_stall_o)
		else $error("Wait not started.");
	a_stall_cause: assert property ($rose(cpu_stall_o) |-> $past(wr_tgt))
		else $error("Stall without a wait.");
endmodule // pin_port_chk
bind pin_port pin_port_chk chk(.clk_sys_i, .reset_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .pin_out_o,
	.pin_oe_o, .cpu_stall_o);

// >>> pin_port_tb.sv
// Self-checking testbench for the pin port.
`timescale 1ns/1ps
module pin_port_tb;
	reg clk_sys_i = 1'b0;
	reg reset_i = 1'b1;
	reg psel_i = 1'b0;
	reg penable_i = 1'b0;
	reg pwrite_i = 1'b0;
	reg [11:0] paddr_i = 12'h000;
	reg [31:0] pwdata_i = 32'h0;
	wire [31:0] prdata_o, pin_in_i, pin_out_o, pin_oe_o;
	wire pready_o, pslverr_o, cpu_stall_o;
	integer n_mismatch = 0;
	integer n_compared = 0;
	integer n;
	reg [31:0] rd, c;
	reg err;
	// The clock runs at 125 MHz.
	always #4 clk_sys_i = ~clk_sys_i;
	pin_port uut(.clk_sys_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pin_in_i,
		.pin_out_o, .pin_oe_o, .cpu_stall_o);
	pin_loads loads(.oe_i(pin_oe_o), .out_i(pin_out_o), .level_o(pin_in_i));
	task report_and_stop;
	begin
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	task check(input string what, input [31:0] exp, input [31:0] got);
	begin
		n_compared = n_compared + 1;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			n_mismatch = n_mismatch + 1;
		end
	end
	endtask
	// One APB transfer; the request holds until ready is sampled high.
	task apb(input w, input [11:0] a, input [31:0] d);
		integer k;
	begin
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys_i);
			k = k + 1;
		end while (pready_o !== 1'b1 && k < 20);
		if (pready_o !== 1'b1) begin
			n_mismatch = n_mismatch + 1;
			report_and_stop;
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	end
	endtask
	task t_regs;
	begin
		apb(0, 12'h000, 0);
		check("dir reset", 32'h0, rd);
		apb(1, 12'h000, 32'hffff0000);
		apb(1, 12'h004, 32'ha5a5a5a5);
		apb(0, 12'h004, 0);
		check("out back", 32'ha5a5a5a5, rd);
		apb(1, 12'h004, rd ^ 32'h00010000);
		repeat (4) @(posedge clk_sys_i);
		check("oe", 32'hffff0000, pin_oe_o);
		check("pins", 32'ha5a40000, pin_out_o);
		apb(0, 12'h014, 0);
		check("pin in", 32'ha5a40000, rd);
		apb(0, 12'h018, 0);
		check("clock rate", 32'd12000, rd);
		apb(1, 12'h020, 32'h1);
		check("err", 1, err);
		$display("t_regs done");
	end
	endtask
	task t_count;
	begin
		apb(0, 12'h008, 0);
		c = rd;
		apb(0, 12'h008, 0);
		check("tick step", c + 32'd3, rd);
		apb(1, 12'h008, 0);
		apb(0, 12'h008, 0);
		check("tick ro", c + 32'd9, rd);
		$display("t_count done");
	end
	endtask
	task t_wait;
	begin
		apb(0, 12'h008, 0);
		apb(1, 12'h00c, rd + 32'd40);
		@(posedge clk_sys_i);
		check("armed", 1, cpu_stall_o);
		for (n = 0; cpu_stall_o === 1'b1 && n < 100; n = n + 1)
			@(posedge clk_sys_i);
		check("wait len", 1, n >= 35 && n <= 39);
		apb(0, 12'h008, 0);
		apb(1, 12'h00c, rd);
		@(posedge clk_sys_i);
		for (n = 0; cpu_stall_o !== 1'b0 && n < 100; n = n + 1)
			@(posedge clk_sys_i);
		check("past target", 100, n);
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(posedge clk_sys_i);
		check("stall reset", 0, cpu_stall_o);
		apb(0, 12'h000, 0);
		check("dir again", 32'h0, rd);
		$display("t_wait done");
	end
	endtask
	// Main sequence after three cycles of reset.
	initial begin
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		t_regs;
		t_count;
		t_wait;
		report_and_stop;
	end
endmodule // pin_port_tb
